// >>> logic/msia_map.vh
// Purpose: Register map, field positions and timing for the master status aggregator
// Assumes: 32-bit AXI4-Lite data, 100 MHz system clock
// Notes:   Definitions only; included by bare name
`ifndef MSIA_MAP_VH
`define MSIA_MAP_VH

// Register indices; byte address is four times the index
`define MSIA_SUMMARY_IDX 8'h08
`define MSIA_MASK_IDX 8'h0a
`define MSIA_ADDR_W 8
`define MSIA_SUMMARY_ADDR 8'h20
`define MSIA_MASK_ADDR 8'h28

// Field positions in summary and mask
`define MSIA_B_SECOND 0
`define MSIA_B_SATURATE 1
`define MSIA_B_BERT 2
`define MSIA_B_HDLC 3
`define MSIA_B_FAR_END 4
`define MSIA_B_FRAME_ALARM 5
`define MSIA_B_REMOTE_ALARM 6
`define MSIA_B_LOOPBACK 8
`define MSIA_B_TOP_FRAMER 9
`define MSIA_B_TX_LOSS 10
`define MSIA_B_RX_LOSS 11
`define MSIA_B_FRAMER_ONLY 12
`define MSIA_B_G747 13

// Count of sticky flags: bits 0..6 then bit 9
`define MSIA_STICKY_N 8
`define MSIA_S_TOP_FRAMER 7

// Writable mask bits and bits able to interrupt (0-6, 8-11)
`define MSIA_MASK_WR 16'h0f7f
`define MSIA_IRQ_CAPABLE 16'h0f7f
`define MSIA_MASK_RST 16'h0000

// AXI response codes
`define MSIA_RESP_OKAY 2'b00
`define MSIA_RESP_SLVERR 2'b10

// Clock-loss timing
`define MSIA_CLK_PERIOD_NS 10
`define MSIA_LOSS_NS 200
`define MSIA_LOSS_CNT_W 8

`endif

// >>> logic/msia_flags.v
// Purpose: Bank of sticky status flags, set by hardware, cleared by a strobe
// Assumes: Set and clear are one-cycle pulses in the clock_in domain
// Notes:   A set arriving with a clear wins, so no event is lost
`timescale 1ns/1ps
`default_nettype none
module msia_flags #(
   parameter W = 8
) (
   input wire clock_in,
   input wire rst_in,
   input wire [W-1:0] set_in,
   input wire [W-1:0] clr_in,
   output wire [W-1:0] flag_out
);
   reg [W-1:0] flag_r; // Held flags
   reg [W-1:0] flag_nxt; // Next flags

   // Set dominates clear
   always @* begin
      flag_nxt = set_in | (flag_r & ~clr_in);
   end

   // Flag storage, cleared by reset
   always @(posedge clock_in) begin
      if (rst_in) begin
         flag_r <= {W{1'b0}};
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_out = flag_r;
endmodule // msia_flags
`default_nettype wire

// >>> logic/msia_clk_watch.v
// Purpose: Flags a line clock that has stopped toggling
// Assumes: Line clock is sampled as an ordinary synchronous input
// Notes:   Flag is set by reset and drops on the first toggle seen
`timescale 1ns/1ps
`default_nettype none
`include "msia_map.vh"
module msia_clk_watch #(
   parameter LOSS_CYC = 20
) (
   input wire clock_in,
   input wire rst_in,
   input wire line_clk_in,
   output wire loss_out
);
   reg prev_r; // Last sampled line level
   reg [`MSIA_LOSS_CNT_W-1:0] idle_r; // Cycles since last toggle
   reg loss_r; // Loss flag
   wire toggle; // Line level changed

   assign toggle = line_clk_in ^ prev_r;

   // Idle counter saturates at the loss limit; a toggle clears it
   always @(posedge clock_in) begin
      if (rst_in) begin
         // Start from the line's own level so a line stuck high gives no false toggle
         prev_r <= line_clk_in;
         idle_r <= {`MSIA_LOSS_CNT_W{1'b0}};
         loss_r <= 1'b1;
      end else begin
         prev_r <= line_clk_in;
         if (toggle) begin
            idle_r <= {`MSIA_LOSS_CNT_W{1'b0}};
            loss_r <= 1'b0;
         end else if (idle_r >= LOSS_CYC[`MSIA_LOSS_CNT_W-1:0] - 1'b1) begin
            loss_r <= 1'b1;
         end else begin
            idle_r <= idle_r + 1'b1;
         end
      end
   end

   assign loss_out = loss_r;
endmodule // msia_clk_watch
`default_nettype wire

// >>> logic/msia_top.v
// Purpose: Master status summary, interrupt mask and one interrupt line
// Assumes: All sub-block event, enable and read strobes are synchronous to clock_in
// Notes:   AXI4-Lite slave; summary at 0x20, mask at 0x28; one access of each kind at a time
`timescale 1ns/1ps
`default_nettype none
`include "msia_map.vh"
module msia_top #(
   parameter LOOP_LINES = 14,
   parameter LOSS_CYC = `MSIA_LOSS_NS / `MSIA_CLK_PERIOD_NS
) (
   input wire clock_in,
   input wire rst_in,
   // AXI4-Lite write address
   input wire [31:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output wire s_axi_awready_out,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output wire s_axi_wready_out,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp_out,
   output wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   // AXI4-Lite read address
   input wire [31:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output wire s_axi_arready_out,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata_out,
   output wire [1:0] s_axi_rresp_out,
   output wire s_axi_rvalid_out,
   input wire s_axi_rready_in,
   // Timer and counters
   input wire one_second_tick_in,
   input wire counter_saturate_in,
   // BERT
   input wire bert_change_in,
   input wire bert_irq_en_in,
   input wire bert_status_reg_rd_in,
   // HDLC
   input wire hdlc_change_in,
   input wire hdlc_irq_enable_reg_in,
   input wire hdlc_status_reg_rd_in,
   // Far-end alarm controller
   input wire far_end_codeword_in,
   input wire far_end_alarm_status_reg_rd_in,
   // Second-level framers
   input wire second_level_frame_alarm_change_in,
   input wire second_level_frame_alarm_en_in,
   input wire second_level_frame_alarm_flag_rd_in,
   input wire second_level_remote_alarm_change_in,
   input wire second_level_remote_alarm_en_in,
   input wire second_level_remote_alarm_flag_rd_in,
   // Tributary loopback detectors, one bit per line
   input wire [LOOP_LINES-1:0] tributary_loopback_status_a_in,
   input wire [LOOP_LINES-1:0] tributary_loopback_status_b_in,
   // Top-level framer
   input wire top_framer_change_in,
   input wire top_framer_en_in,
   input wire top_framer_status_flag_rd_in,
   // Line clocks and mode pins
   input wire framer_tx_clock_in,
   input wire line_rx_clock_in,
   input wire framer_only_select_pin_in,
   input wire g747_select_pin_in,
   // Interrupt, active high
   output wire irq_out
);
   // Bus state
   reg awready_r; // Ready for write address
   reg wready_r; // Ready for write data
   reg aw_held_r; // Write address captured
   reg w_held_r; // Write data captured
   reg [`MSIA_ADDR_W-1:0] aw_addr_r; // Captured write address
   reg [31:0] w_data_r; // Captured write data
   reg [3:0] w_strb_r; // Captured byte strobes
   reg bvalid_r; // Write response pending
   reg [1:0] bresp_r; // Write response code
   reg arready_r; // Ready for read address
   reg rvalid_r; // Read data pending
   reg [1:0] rresp_r; // Read response code
   reg [31:0] rdata_r; // Read data

   // Block state
   reg [15:0] mask_r; // master_interrupt_mask
   reg loopback_r; // Any loopback command active
   reg framer_only_r; // Framer-only pin level
   reg g747_r; // G.747 pin level
   reg irq_r; // Registered interrupt

   // Combinational helpers
   wire aw_fire; // Write address handshake
   wire w_fire; // Write data handshake
   wire ar_fire; // Read address handshake
   wire wr_go; // Both halves of a write present
   wire [`MSIA_ADDR_W-1:0] wr_addr; // Effective write address
   wire [31:0] wr_data; // Effective write data
   wire [3:0] wr_strb; // Effective strobes
   wire [`MSIA_ADDR_W-1:0] rd_addr; // Read address low bits
   wire summary_rd; // Read of summary taken
   wire [`MSIA_STICKY_N-1:0] sticky_set; // Flag sets
   wire [`MSIA_STICKY_N-1:0] sticky_clr; // Flag clears
   wire [`MSIA_STICKY_N-1:0] sticky; // Flag values
   wire tx_loss; // Tx clock lost
   wire rx_loss; // Rx clock lost
   reg [15:0] summary; // Assembled summary word
   reg [15:0] mask_nxt; // Next mask value

   assign aw_fire = s_axi_awvalid_in & awready_r;
   assign w_fire = s_axi_wvalid_in & wready_r;
   assign ar_fire = s_axi_arvalid_in & arready_r;
   // Address and data may arrive in either order or together
   assign wr_go = (aw_held_r | aw_fire) & (w_held_r | w_fire) & ~bvalid_r;
   assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr_in[`MSIA_ADDR_W-1:0];
   assign wr_data = w_held_r ? w_data_r : s_axi_wdata_in;
   assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb_in;
   assign rd_addr = s_axi_araddr_in[`MSIA_ADDR_W-1:0];
   assign summary_rd = ar_fire & (rd_addr == `MSIA_SUMMARY_ADDR);

   // Sticky flag sources; BERT, HDLC, both alarm and top framer sets are gated by their sub-block enable
   assign sticky_set[`MSIA_B_SECOND] = one_second_tick_in;
   assign sticky_set[`MSIA_B_SATURATE] = counter_saturate_in;
   assign sticky_set[`MSIA_B_BERT] = bert_change_in & bert_irq_en_in;
   assign sticky_set[`MSIA_B_HDLC] = hdlc_change_in & hdlc_irq_enable_reg_in;
   assign sticky_set[`MSIA_B_FAR_END] = far_end_codeword_in;
   assign sticky_set[`MSIA_B_FRAME_ALARM] =
      second_level_frame_alarm_change_in & second_level_frame_alarm_en_in;
   assign sticky_set[`MSIA_B_REMOTE_ALARM] =
      second_level_remote_alarm_change_in & second_level_remote_alarm_en_in;
   assign sticky_set[`MSIA_S_TOP_FRAMER] = top_framer_change_in & top_framer_en_in;

   // Event bits clear on a summary read; the rest on their own register read
   assign sticky_clr[`MSIA_B_SECOND] = summary_rd;
   assign sticky_clr[`MSIA_B_SATURATE] = summary_rd;
   assign sticky_clr[`MSIA_B_BERT] = bert_status_reg_rd_in;
   assign sticky_clr[`MSIA_B_HDLC] = hdlc_status_reg_rd_in;
   assign sticky_clr[`MSIA_B_FAR_END] = far_end_alarm_status_reg_rd_in;
   assign sticky_clr[`MSIA_B_FRAME_ALARM] = second_level_frame_alarm_flag_rd_in;
   assign sticky_clr[`MSIA_B_REMOTE_ALARM] = second_level_remote_alarm_flag_rd_in;
   assign sticky_clr[`MSIA_S_TOP_FRAMER] = top_framer_status_flag_rd_in;

   // Flags hold until cleared, which keeps the interrupt up until serviced
   msia_flags #(
      .W(`MSIA_STICKY_N)
   ) u_flags (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .set_in(sticky_set),
      .clr_in(sticky_clr),
      .flag_out(sticky)
   );

   // Tx clock watched against the system clock
   msia_clk_watch #(
      .LOSS_CYC(LOSS_CYC)
   ) u_tx_watch (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .line_clk_in(framer_tx_clock_in),
      .loss_out(tx_loss)
   );

   // Rx clock watched against the system clock
   msia_clk_watch #(
      .LOSS_CYC(LOSS_CYC)
   ) u_rx_watch (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .line_clk_in(line_rx_clock_in),
      .loss_out(rx_loss)
   );

   // Assemble the summary word; unused positions stay zero
   always @* begin
      summary = 16'h0000;
      summary[`MSIA_B_REMOTE_ALARM:`MSIA_B_SECOND] = sticky[`MSIA_B_REMOTE_ALARM:0];
      summary[`MSIA_B_LOOPBACK] = loopback_r;
      summary[`MSIA_B_TOP_FRAMER] = sticky[`MSIA_S_TOP_FRAMER];
      summary[`MSIA_B_TX_LOSS] = tx_loss;
      summary[`MSIA_B_RX_LOSS] = rx_loss;
      summary[`MSIA_B_FRAMER_ONLY] = framer_only_r;
      summary[`MSIA_B_G747] = g747_r;
   end

   // Mask write honours the two low byte lanes; unused bits never store
   always @* begin
      mask_nxt = mask_r;
      if (wr_go && wr_addr == `MSIA_MASK_ADDR) begin
         if (wr_strb[0]) begin
            mask_nxt[7:0] = wr_data[7:0];
         end
         if (wr_strb[1]) begin
            mask_nxt[15:8] = wr_data[15:8];
         end
         mask_nxt = mask_nxt & `MSIA_MASK_WR;
      end
   end

   // Level bits, mask and interrupt
   always @(posedge clock_in) begin
      if (rst_in) begin
         mask_r <= `MSIA_MASK_RST;
         loopback_r <= 1'b0;
         framer_only_r <= 1'b0;
         g747_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         mask_r <= mask_nxt;
         // Drops only when no line reports an active command
         loopback_r <= (|tributary_loopback_status_a_in) |
            (|tributary_loopback_status_b_in);
         framer_only_r <= framer_only_select_pin_in;
         g747_r <= g747_select_pin_in;
         // Pin mirrors are excluded from the capable set
         irq_r <= |(summary & mask_r & `MSIA_IRQ_CAPABLE);
      end
   end

   // Write channel: capture each half, answer once both are in
   always @(posedge clock_in) begin
      if (rst_in) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= {`MSIA_ADDR_W{1'b0}};
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `MSIA_RESP_OKAY;
      end else begin
         if (wr_go) begin
            // Both halves present: respond, stop taking new ones
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b1;
            if (wr_addr == `MSIA_MASK_ADDR || wr_addr == `MSIA_SUMMARY_ADDR) begin
               // Summary is read-only; write is accepted and ignored
               bresp_r <= `MSIA_RESP_OKAY;
            end else begin
               bresp_r <= `MSIA_RESP_SLVERR;
            end
         end else begin
            if (aw_fire) begin
               aw_held_r <= 1'b1;
               aw_addr_r <= s_axi_awaddr_in[`MSIA_ADDR_W-1:0];
               awready_r <= 1'b0;
            end
            if (w_fire) begin
               w_held_r <= 1'b1;
               w_data_r <= s_axi_wdata_in;
               w_strb_r <= s_axi_wstrb_in;
               wready_r <= 1'b0;
            end
            if (bvalid_r && s_axi_bready_in) begin
               // Response taken: reopen both channels
               bvalid_r <= 1'b0;
               awready_r <= 1'b1;
               wready_r <= 1'b1;
            end
         end
      end
   end

   // Read channel: one outstanding read, data one edge after address
   always @(posedge clock_in) begin
      if (rst_in) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rresp_r <= `MSIA_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end else begin
         if (ar_fire) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            case (rd_addr)
               `MSIA_SUMMARY_ADDR: begin
                  // Captured before the read clears the event bits
                  rdata_r <= {16'h0000, summary};
                  rresp_r <= `MSIA_RESP_OKAY;
               end
               `MSIA_MASK_ADDR: begin
                  rdata_r <= {16'h0000, mask_r};
                  rresp_r <= `MSIA_RESP_OKAY;
               end
               default: begin
                  rdata_r <= 32'h00000000;
                  rresp_r <= `MSIA_RESP_SLVERR;
               end
            endcase
         end else if (rvalid_r && s_axi_rready_in) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   assign s_axi_awready_out = awready_r;
   assign s_axi_wready_out = wready_r;
   assign s_axi_bvalid_out = bvalid_r;
   assign s_axi_bresp_out = bresp_r;
   assign s_axi_arready_out = arready_r;
   assign s_axi_rvalid_out = rvalid_r;
   assign s_axi_rresp_out = rresp_r;
   assign s_axi_rdata_out = rdata_r;
   assign irq_out = irq_r;
endmodule // msia_top
`default_nettype wire

// >>> test/msia_top_assertions.sv
// Purpose: Port-level checks on the master status aggregator
// Assumes: One clock domain, synchronous active-high reset
// Notes: Loss checks keep a few cycles of margin around the limit
`timescale 1ns/1ps
`default_nettype none
`include "msia_map.vh"
module msia_top_checker #(
   parameter LOSS_CYC = 20
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [31:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rvalid_out,
   input wire logic framer_tx_clock_in,
   input wire logic line_rx_clock_in,
   input wire logic framer_only_select_pin_in,
   input wire logic g747_select_pin_in,
   input wire logic irq_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   logic [7:0] tx_idle_r, rx_idle_r; // Edges since last change; all ones means never seen
   logic tx_prev_r, rx_prev_r, rv_r, sum_r;
   wire rd_sum = s_axi_rvalid_out && !rv_r && sum_r; // First cycle of a summary answer
   // Idle counters saturate so a dead clock stays dead
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         tx_prev_r <= framer_tx_clock_in;
         rx_prev_r <= line_rx_clock_in;
         tx_idle_r <= 8'hff;
         rx_idle_r <= 8'hff;
         rv_r <= 1'b0;
         sum_r <= 1'b0;
      end else begin
         tx_prev_r <= framer_tx_clock_in;
         rx_prev_r <= line_rx_clock_in;
         tx_idle_r <= (framer_tx_clock_in != tx_prev_r) ? 8'h00 : tx_idle_r + {7'h0, ~&tx_idle_r};
         rx_idle_r <= (line_rx_clock_in != rx_prev_r) ? 8'h00 : rx_idle_r + {7'h0, ~&rx_idle_r};
         rv_r <= s_axi_rvalid_out;
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            sum_r <= (s_axi_araddr_in[7:0] == `MSIA_SUMMARY_ADDR);
         end
      end
   end
   rd_unused_zero_a: assert property (
      rd_sum |-> s_axi_rdata_out[31:14] == 18'h0 && !s_axi_rdata_out[7]) else $error("unused bits set");
   framer_pin_a: assert property (
      rd_sum && $stable(framer_only_select_pin_in) && $past(framer_only_select_pin_in, 2)
      == framer_only_select_pin_in |-> s_axi_rdata_out[12] == framer_only_select_pin_in)
      else $error("mode pin bit wrong");
   g747_pin_a: assert property (
      rd_sum && $stable(g747_select_pin_in) && $past(g747_select_pin_in, 2) == g747_select_pin_in
      |-> s_axi_rdata_out[13] == g747_select_pin_in) else $error("g747 bit wrong");
   tx_loss_set_a: assert property (
      rd_sum && tx_idle_r >= LOSS_CYC + 4 |-> s_axi_rdata_out[10]) else $error("tx loss missing");
   tx_loss_clr_a: assert property (
      rd_sum && tx_idle_r inside {[1:LOSS_CYC - 4]} |-> !s_axi_rdata_out[10])
      else $error("tx loss stuck");
   rx_loss_set_a: assert property (
      rd_sum && rx_idle_r >= LOSS_CYC + 4 |-> s_axi_rdata_out[11]) else $error("rx loss missing");
   rx_loss_clr_a: assert property (
      rd_sum && rx_idle_r inside {[1:LOSS_CYC - 4]} |-> !s_axi_rdata_out[11])
      else $error("rx loss stuck");
   irq_after_reset_a: assert property (
      $fell(rst_in) |-> !irq_out [*3]) else $error("irq with mask clear");
   cover property ($rose(irq_out));
   cover property (rd_sum && s_axi_rdata_out[10]);
   cover property (rd_sum && s_axi_rdata_out[11]);
endmodule // msia_top_checker
`default_nettype wire

// >>> test/msia_line_src.sv
// Purpose: Far-side line clock sources
// Assumes: Each clock toggles only while its run input is high
// Notes: Periods unrelated to the system clock so phases drift
`timescale 1ns/1ps
`default_nettype none
module msia_line_src (
   input wire logic tx_run_in,
   input wire logic rx_run_in,
   output var logic framer_tx_clock_out,
   output var logic line_rx_clock_out
);
   // A stopped line holds its last level, like a dead cable
   // Half-ns offset keeps every line edge clear of a system clock edge
   initial begin
      framer_tx_clock_out = 1'b0;
      #0.5;
      forever #11 if (tx_run_in) framer_tx_clock_out = ~framer_tx_clock_out;
   end
   initial begin
      line_rx_clock_out = 1'b0;
      #0.5;
      forever #13 if (rx_run_in) line_rx_clock_out = ~line_rx_clock_out;
   end
endmodule // msia_line_src
`default_nettype wire

// >>> test/msia_top_tb.sv
// Purpose: Self-checking bench for the master status aggregator
// Assumes: Registers reached through AXI4-Lite tasks
// Notes: Line clocks come from the far-side model and can be stopped
`timescale 1ns/1ps
`default_nettype none
`include "msia_map.vh"
module msia_top_tb;
   logic clock_in, rst_in, awv, wv, brdy, arv, rrdy, pin_fo, pin_g, tx_run, rx_run;
   logic [31:0] awa, wd, ara, rdata;
   logic [3:0] ws;
   logic [1:0] resp;
   logic [7:0] set_v, en_v, rd_v; // Sticky sources: bits 0..6, then top framer
   logic [13:0] lb_a, lb_b;
   wire awr, wr_rdy, bv, arr, rv, irq, ftx, lrx;
   wire [1:0] br, rr;
   wire [31:0] rd_w;
   int bad_count, checked;
   msia_top #(.LOOP_LINES(14)) u_dut (.clock_in(clock_in), .rst_in(rst_in),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rd_w), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy),
      .one_second_tick_in(set_v[0]), .counter_saturate_in(set_v[1]),
      .bert_change_in(set_v[2]), .bert_irq_en_in(en_v[2]), .bert_status_reg_rd_in(rd_v[2]),
      .hdlc_change_in(set_v[3]), .hdlc_irq_enable_reg_in(en_v[3]),
      .hdlc_status_reg_rd_in(rd_v[3]), .far_end_codeword_in(set_v[4]),
      .far_end_alarm_status_reg_rd_in(rd_v[4]), .second_level_frame_alarm_change_in(set_v[5]),
      .second_level_frame_alarm_en_in(en_v[5]), .second_level_frame_alarm_flag_rd_in(rd_v[5]),
      .second_level_remote_alarm_change_in(set_v[6]), .second_level_remote_alarm_en_in(en_v[6]),
      .second_level_remote_alarm_flag_rd_in(rd_v[6]), .tributary_loopback_status_a_in(lb_a),
      .tributary_loopback_status_b_in(lb_b), .top_framer_change_in(set_v[7]),
      .top_framer_en_in(en_v[7]), .top_framer_status_flag_rd_in(rd_v[7]),
      .framer_tx_clock_in(ftx), .line_rx_clock_in(lrx), .framer_only_select_pin_in(pin_fo),
      .g747_select_pin_in(pin_g), .irq_out(irq));
   msia_line_src u_src (.tx_run_in(tx_run), .rx_run_in(rx_run),
      .framer_tx_clock_out(ftx), .line_rx_clock_out(lrx));
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: irq %b expected %b", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   // A hung handshake counts as a mismatch and ends the run
   task automatic limit(input int n);
      if (n >= 200) begin
         bad_count++;
         end_sim();
      end
   endtask
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      awa <= {24'h000000, a};
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge clock_in);
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
         n++;
      end while (!bv && n < 200);
      resp = br;
      limit(n);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      ara <= {24'h000000, a};
      arv <= 1'b1;
      do begin
         @(posedge clock_in);
         if (arr) arv <= 1'b0;
         n++;
      end while (!rv && n < 200);
      rdata = rd_w;
      resp = rr;
      limit(n);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      rd(a);
      chk32(rdata, {16'h0000, e});
   endtask
   // One-cycle strobe on a sticky source, set or clear side
   task automatic pulse(input int i, input logic clr);
      if (clr) rd_v[i] <= 1'b1;
      else set_v[i] <= 1'b1;
      @(posedge clock_in);
      set_v <= 8'h00;
      rd_v <= 8'h00;
   endtask
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial begin
      logic [15:0] base, b;
      int pos [8];
      pos = '{0, 1, 2, 3, 4, 5, 6, 9};
      bad_count = 0;
      checked = 0;
      // Response ready lines stay high, so back-to-back calls never re-drive them
      {rst_in, awv, wv, brdy, arv, rrdy, pin_fo, pin_g, tx_run, rx_run} = 10'b1001011000;
      {awa, wd, ara, ws, set_v, en_v, rd_v, lb_a, lb_b} = '0;
      cyc(16);
      rst_in <= 1'b0;
      cyc(4);
      base = 16'h1000; // Framer-only pin high, g747 pin low
      rdc(`MSIA_SUMMARY_ADDR, base | 16'h0c00);
      rdc(`MSIA_MASK_ADDR, `MSIA_MASK_RST);
      tx_run <= 1'b1;
      rx_run <= 1'b1;
      pin_fo <= 1'b0;
      pin_g <= 1'b1;
      base = 16'h2000;
      cyc(10);
      rdc(`MSIA_SUMMARY_ADDR, base);
      wr(`MSIA_MASK_ADDR, 32'hffffffff, 4'hf);
      rdc(`MSIA_MASK_ADDR, 16'h0f7f);
      wr(`MSIA_MASK_ADDR, 32'h00000000, 4'h1);
      rdc(`MSIA_MASK_ADDR, 16'h0f00);
      wr(`MSIA_SUMMARY_ADDR, 32'h0000ffff, 4'hf);
      chk32({30'h0, resp}, {30'h0, `MSIA_RESP_OKAY});
      rdc(`MSIA_SUMMARY_ADDR, base);
      rdc(8'h30, 16'h0000);
      chk32({30'h0, resp}, {30'h0, `MSIA_RESP_SLVERR});
      wr(8'h30, 32'h0000ffff, 4'hf);
      chk32({30'h0, resp}, {30'h0, `MSIA_RESP_SLVERR});
      wr(`MSIA_MASK_ADDR, 32'h00000f7f, 4'hf);
      chk1(irq, 1'b0);
      // Each sticky source: gated by enable except bits 0, 1 and 4, held until cleared, masked
      for (int i = 0; i < 8; i++) begin
         b = 16'h0001 << pos[i];
         en_v <= 8'h00;
         pulse(i, 1'b0);
         rdc(`MSIA_SUMMARY_ADDR, base | ((i < 2 || i == 4) ? b : 16'h0000));
         en_v <= 8'hff;
         pulse(i, 1'b0);
         cyc(3);
         chk1(irq, 1'b1);
         wr(`MSIA_MASK_ADDR, {16'h0000, 16'h0f7f & ~b}, 4'hf);
         cyc(3);
         chk1(irq, 1'b0);
         wr(`MSIA_MASK_ADDR, 32'h00000f7f, 4'hf);
         rdc(`MSIA_SUMMARY_ADDR, base | b);
         if (i > 1) pulse(i, 1'b1);
         rdc(`MSIA_SUMMARY_ADDR, base);
         cyc(3);
         chk1(irq, 1'b0);
      end
      // Loopback follows its inputs and survives reads
      lb_a[3] <= 1'b1;
      cyc(3);
      rdc(`MSIA_SUMMARY_ADDR, base | 16'h0100);
      chk1(irq, 1'b1);
      lb_a[3] <= 1'b0;
      lb_b[13] <= 1'b1;
      cyc(3);
      rdc(`MSIA_SUMMARY_ADDR, base | 16'h0100);
      lb_b[13] <= 1'b0;
      cyc(3);
      rdc(`MSIA_SUMMARY_ADDR, base);
      // Stop each line clock in turn, then restart it
      for (int k = 0; k < 2; k++) begin
         b = 16'h0400 << k;
         if (k == 0) tx_run <= 1'b0;
         else rx_run <= 1'b0;
         cyc(30);
         rdc(`MSIA_SUMMARY_ADDR, base | b);
         chk1(irq, 1'b1);
         tx_run <= 1'b1;
         rx_run <= 1'b1;
         cyc(6);
         rdc(`MSIA_SUMMARY_ADDR, base);
      end
      end_sim();
   end
endmodule // msia_top_tb
bind msia_top msia_top_checker #(.LOSS_CYC(LOSS_CYC)) u_chk (.clock_in(clock_in),
   .rst_in(rst_in), .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .framer_tx_clock_in(framer_tx_clock_in),
   .line_rx_clock_in(line_rx_clock_in), .framer_only_select_pin_in(framer_only_select_pin_in),
   .g747_select_pin_in(g747_select_pin_in), .irq_out(irq_out));
`default_nettype wire
